/* hw/lcdmx_top.sv */
// Purpose: function select for eighteen segment pins: LCD, port, CD signals
// Assumes: common index and frame phase come from the common timing block
// Notes: pin level codes drive the bias switches; oe low leaves pin floating
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module lcdmx_top
  import lcdmx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // common timing
  input wire logic [1:0] lcd_common_index,
  input wire logic lcd_frame_phase,
  // cd processor signals
  input wire logic cd_subcode_clk,
  input wire logic cd_subcode_load,
  input wire logic [7:0] cd_subcode_byte,
  input wire logic cd_frame_sync,
  input wire logic cd_channel_clk,
  input wire logic cd_bit_clk,
  input wire logic cd_audio_data,
  input wire logic cd_overflow,
  input wire logic cd_interp,
  input wire logic cd_zero,
  // pins
  input wire logic subclk_pin_in,
  input wire logic [NUM_SHARED-1:0] shared_port_bit_in,
  output logic [NUM_PINS-1:0][1:0] pin_level_o,
  output logic [NUM_PINS-1:0] pin_oe_o
);
  localparam int SYNC_W = NUM_SHARED + 1;

  typedef struct packed {
    lcdmx_bus_t phase;
    logic ack;
    logic [31:0] dat;
    logic [CTRL_W-1:0] ctrl;
    logic [NUM_PINS-1:0] port_sel;
    logic [NUM_PINS-1:0] port_data;
    logic [NUM_SHARED-1:0] shared_dir;
    logic [NUM_CD_SEL-1:0] cd_sel;
    logic [NUM_PINS-1:0] disp_word;
    logic disp_rd;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] stable;
    logic clk_prev;
    logic [7:0] sub_shift;
    logic sub_bit;
    logic [NUM_PINS-1:0][1:0] pin_level;
    logic [NUM_PINS-1:0] pin_oe;
  } lcdmx_state_t;

  lcdmx_state_t state_reg;
  lcdmx_state_t state_next;
  lcdmx_seg_if seg ();

  logic [NUM_PINS-1:0] cd_en_c;
  logic [NUM_PINS-1:0] cd_val_c;
  logic [NUM_PINS-1:0][1:0] lvl_c;
  logic [NUM_PINS-1:0] oe_c;
  logic subclk_now;
  logic bus_req;
  logic seg_hit;

  lcdmx_seg_mem u_mem (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .port(seg.mem)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ------------------------------------------------------------
  // cd function selection
  // ------------------------------------------------------------
  always_comb
  begin
    cd_en_c = '0;
    cd_en_c[PIN_CHAN] = state_reg.ctrl[CTRL_BATCH_CD];
    cd_en_c[PIN_BITCLK] = state_reg.ctrl[CTRL_BATCH_CD];
    cd_en_c[PIN_AUDIO] = state_reg.ctrl[CTRL_BATCH_CD];
    cd_en_c[PIN_ZERO] = state_reg.cd_sel[0];
    cd_en_c[PIN_SUBCLK] = state_reg.cd_sel[1];
    cd_en_c[PIN_SUBDATA] = state_reg.cd_sel[2];
    cd_en_c[PIN_FSYNC] = state_reg.cd_sel[3];
    cd_en_c[PIN_OVF] = state_reg.cd_sel[4];
    cd_en_c[PIN_INTERP] = state_reg.cd_sel[5];
    cd_val_c = '0;
    cd_val_c[PIN_ZERO] = cd_zero;
    cd_val_c[PIN_SUBCLK] = cd_subcode_clk;
    cd_val_c[PIN_SUBDATA] = state_reg.sub_bit;
    cd_val_c[PIN_FSYNC] = cd_frame_sync;
    cd_val_c[PIN_CHAN] = cd_channel_clk ^ state_reg.ctrl[CTRL_CHAN_INV];
    cd_val_c[PIN_BITCLK] = cd_bit_clk;
    cd_val_c[PIN_AUDIO] = cd_audio_data;
    cd_val_c[PIN_OVF] = cd_overflow;
    cd_val_c[PIN_INTERP] = cd_interp;
  end

  // ------------------------------------------------------------
  // per-pin function mux
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      logic on;
      logic [1:0] lcd_lvl;
      assign on = state_reg.disp_word[gi];
      assign lcd_lvl = state_reg.ctrl[CTRL_THIRD_BIAS]
        ? (on ? (lcd_frame_phase ? LVL_GND : LVL_VDD)
              : (lcd_frame_phase ? LVL_TWO_THIRDS : LVL_THIRD))
        : ((on ^ lcd_frame_phase) ? LVL_VDD : LVL_GND);
      if (gi == PIN_SUBCLK)
      begin : g_subclk
        always_comb
        begin
          if (cd_en_c[gi])
          begin
            lvl_c[gi] = cd_val_c[gi] ? LVL_VDD : LVL_GND;
            oe_c[gi] = state_reg.ctrl[CTRL_SUBCLK_DRIVE];
          end
          else if (state_reg.port_sel[gi])
          begin
            lvl_c[gi] = state_reg.port_data[gi] ? LVL_VDD : LVL_GND;
            oe_c[gi] = 1'b1;
          end
          else
          begin
            lvl_c[gi] = lcd_lvl;
            oe_c[gi] = 1'b1;
          end
        end
      end
      else if (gi < NUM_OUT_ONLY)
      begin : g_out
        always_comb
        begin
          if (cd_en_c[gi])
          begin
            lvl_c[gi] = cd_val_c[gi] ? LVL_VDD : LVL_GND;
          end
          else if (state_reg.port_sel[gi])
          begin
            lvl_c[gi] = state_reg.port_data[gi] ? LVL_VDD : LVL_GND;
          end
          else
          begin
            lvl_c[gi] = lcd_lvl;
          end
          oe_c[gi] = 1'b1;
        end
      end
      else
      begin : g_shared
        always_comb
        begin
          if (cd_en_c[gi])
          begin
            lvl_c[gi] = cd_val_c[gi] ? LVL_VDD : LVL_GND;
            oe_c[gi] = 1'b1;
          end
          else if (state_reg.port_sel[gi])
          begin
            // open drain: only ever pulls low
            lvl_c[gi] = LVL_GND;
            oe_c[gi] = state_reg.shared_dir[gi-NUM_OUT_ONLY] & ~state_reg.port_data[gi];
          end
          else
          begin
            lvl_c[gi] = lcd_lvl;
            oe_c[gi] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign seg_hit = (wb_adr_i >= OFS_SEG_BASE) && (wb_adr_i <= OFS_SEG_LAST);
  assign subclk_now = state_reg.ctrl[CTRL_SUBCLK_DRIVE] ? cd_subcode_clk
                                                        : state_reg.stable[NUM_SHARED];

  always_comb
  begin
    state_next = state_reg;
    seg.we = 1'b0;
    seg.waddr = wb_adr_i[3:2];
    seg.wdata = NUM_PINS'(merge({14'h0000, seg.rdata}, wb_dat_i, wb_sel_i));
    seg.raddr = lcd_common_index;
    state_next.disp_rd = 1'b1;
    // pin inputs: change counts once second and third stage agree
    state_next.sync1 = {subclk_pin_in, shared_port_bit_in};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    state_next.stable = (state_reg.sync2 & state_reg.sync3)
      | (state_reg.stable & (state_reg.sync2 ^ state_reg.sync3));
    // subcode bits leave msb first on each rising subcode clock
    state_next.clk_prev = subclk_now;
    if (cd_subcode_load)
    begin
      state_next.sub_shift = cd_subcode_byte;
    end
    else if (subclk_now && !state_reg.clk_prev)
    begin
      state_next.sub_bit = state_reg.sub_shift[7];
      state_next.sub_shift = {state_reg.sub_shift[6:0], 1'b0};
    end
    if (state_reg.disp_rd)
    begin
      state_next.disp_word = seg.rdata;
    end
    case (state_reg.phase)
      LCDMX_BUS_IDLE:
      begin
        state_next.ack = 1'b0;
        if (bus_req)
        begin
          state_next.phase = LCDMX_BUS_BUSY;
          if (seg_hit)
          begin
            // bus borrows the read port for one cycle
            seg.raddr = wb_adr_i[3:2];
            state_next.disp_rd = 1'b0;
          end
        end
      end
      LCDMX_BUS_BUSY:
      begin
        state_next.phase = LCDMX_BUS_ACK;
        state_next.ack = 1'b1;
        state_next.dat = 32'h0000_0000;
        if (wb_adr_i == OFS_CTRL)
        begin
          state_next.dat = {28'h000_0000, state_reg.ctrl};
          if (wb_we_i)
          begin
            state_next.ctrl = CTRL_W'(merge({28'h000_0000, state_reg.ctrl},
                                            wb_dat_i, wb_sel_i));
          end
        end
        else if (wb_adr_i == OFS_PORT_SEL)
        begin
          state_next.dat = {14'h0000, state_reg.port_sel};
          if (wb_we_i)
          begin
            state_next.port_sel = NUM_PINS'(merge({14'h0000, state_reg.port_sel},
                                                  wb_dat_i, wb_sel_i));
          end
        end
        else if (wb_adr_i == OFS_PORT_DATA)
        begin
          state_next.dat = {14'h0000, state_reg.port_data};
          if (wb_we_i)
          begin
            state_next.port_data = NUM_PINS'(merge({14'h0000, state_reg.port_data},
                                                   wb_dat_i, wb_sel_i));
          end
        end
        else if (wb_adr_i == OFS_STEP)
        begin
          state_next.dat = {14'h0000, state_reg.port_data};
          if (wb_we_i)
          begin
            state_next.port_data = {state_reg.port_data[NUM_PINS-2:0],
                                    state_reg.port_data[NUM_PINS-1]};
          end
        end
        else if (wb_adr_i == OFS_SHARED_DIR)
        begin
          state_next.dat = {28'h000_0000, state_reg.shared_dir};
          if (wb_we_i)
          begin
            state_next.shared_dir = NUM_SHARED'(merge({28'h000_0000, state_reg.shared_dir},
                                                      wb_dat_i, wb_sel_i));
          end
        end
        else if (wb_adr_i == OFS_PIN_STATE)
        begin
          state_next.dat = {9'h000, state_reg.stable, state_reg.pin_oe};
        end
        else if (seg_hit)
        begin
          state_next.dat = {14'h0000, seg.rdata};
          if (wb_we_i)
          begin
            seg.we = 1'b1;
            state_next.cd_sel[wb_adr_i[3:2]*3 +: 3] =
              seg.wdata[SEG_CD_SEL_LSB +: 3];
          end
        end
      end
      default:
      begin
        state_next.phase = LCDMX_BUS_IDLE;
        state_next.ack = 1'b0;
      end
    endcase
    state_next.pin_level = lvl_c;
    state_next.pin_oe = oe_c;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
      state_reg.phase <= LCDMX_BUS_IDLE;
      state_reg.ctrl <= RST_CTRL;
      state_reg.port_sel <= RST_PORT_SEL;
      state_reg.port_data <= RST_PORT_DATA;
      state_reg.shared_dir <= RST_SHARED_DIR;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o = state_reg.dat;
  assign wb_ack_o = state_reg.ack;
  assign pin_level_o = state_reg.pin_level;
  assign pin_oe_o = state_reg.pin_oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_half_bias_two: assert property (
    (!state_reg.ctrl[CTRL_THIRD_BIAS] && !state_reg.port_sel[0])
      |=> (pin_level_o[0] == LVL_VDD || pin_level_o[0] == LVL_GND))
    else $error("half bias pin shows a middle level");
  a_third_bias_mid: assert property (
    (state_reg.ctrl[CTRL_THIRD_BIAS] && !state_reg.port_sel[0] && !state_reg.disp_word[0])
      |=> (pin_level_o[0] == LVL_THIRD || pin_level_o[0] == LVL_TWO_THIRDS))
    else $error("third bias unlit segment not at middle level");
  a_shared_open_drain: assert property (
    (state_reg.port_sel[PIN_INTERP] && !cd_en_c[PIN_INTERP])
      |=> (pin_level_o[PIN_INTERP] == LVL_GND))
    else $error("shared port pin drives high");
  a_batch_cd_pins: assert property (
    state_reg.ctrl[CTRL_BATCH_CD]
      |=> (pin_level_o[PIN_BITCLK] == ($past(cd_bit_clk) ? LVL_VDD : LVL_GND)
           && pin_oe_o[PIN_AUDIO]))
    else $error("batch cd pins not following cd signals");
  a_chan_polarity: assert property (
    state_reg.ctrl[CTRL_BATCH_CD] |=> (pin_level_o[PIN_CHAN] ==
      (($past(cd_channel_clk) ^ $past(state_reg.ctrl[CTRL_CHAN_INV])) ? LVL_VDD : LVL_GND)))
    else $error("channel clock polarity wrong");
  a_step_rotates: assert property (
    (state_reg.phase == LCDMX_BUS_BUSY && wb_we_i && wb_adr_i == OFS_STEP)
      |=> (state_reg.port_data == {$past(state_reg.port_data[NUM_PINS-2:0]),
                                   $past(state_reg.port_data[NUM_PINS-1])}))
    else $error("step did not advance output bit");
  a_ack_pulse: assert property (
    (bus_req && state_reg.phase == LCDMX_BUS_IDLE) |-> ##2 wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse two cycles after request");
  a_subclk_input: assert property (
    (cd_en_c[PIN_SUBCLK] && !state_reg.ctrl[CTRL_SUBCLK_DRIVE]) |=> !pin_oe_o[PIN_SUBCLK])
    else $error("subcode clock driven while in input mode");
  a_overflow_pin: assert property (
    cd_en_c[PIN_OVF] |=> (pin_level_o[PIN_OVF] == ($past(cd_overflow) ? LVL_VDD : LVL_GND)))
    else $error("overflow pin does not follow overflow");
endmodule
`default_nettype wire

/* inc/lcdmx_pkg.sv */
// Purpose: constants and types for the segment pin multiplexer
// Assumes: 40 MHz system clock, classic Wishbone register access
// Notes: level codes select the analogue bias switches of each pin
//
// Behaviour
// - half bias: segment pins drive only supply or ground
// - third bias: segment pins drive supply, one third, two thirds or ground
// - eighteen segments against four commons address 72 segments
// - segment pins one to fourteen switch to output port under program
// - four shared port pins switch individually between segment and I/O port
// - shared port pins in I/O mode are open drain, pull low only
// - segments ten to fourteen and shared port pins can carry CD signals
// - batch select bit moves channel clock, bit clock, audio pins to CD
// - other CD pins select individually from segment data of segments 14-16
// - subcode clock pin is bidirectional, clocks subcode bits P to W
// - subcode data pin shifts out P to W bits on subcode clock
// - frame sync pin outputs subcode frame synchronisation
// - channel clock toggles 44.1 kHz, low left, high right
// - channel clock polarity inverts on command
// - bit clock pin carries 1.4112 MHz clock, audio pin carries samples
// - overflow pin high while buffer memory overflows
// - interpolation pin high for uncorrectable audio words
// - zero pin outputs one-bit converter zero detection flag
// - output port pins also serve as LED segment outputs
// - step instruction advances active output bit through positions one to 18
// - after reset, output-port pins default to LCD segment output
// - after reset, I/O port pins default to input
package lcdmx_pkg;
  localparam int NUM_PINS = 18;
  localparam int NUM_COMMONS = 4;
  localparam int NUM_OUT_ONLY = 14;
  localparam int NUM_SHARED = 4;
  localparam int NUM_CD_SEL = 12;
  localparam int ADR_W = 8;
  // pin level codes
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_THIRD = 2'h1;
  localparam logic [1:0] LVL_TWO_THIRDS = 2'h2;
  localparam logic [1:0] LVL_VDD = 2'h3;
  // pin indices carrying CD functions
  localparam int PIN_ZERO = 9;
  localparam int PIN_SUBCLK = 10;
  localparam int PIN_SUBDATA = 11;
  localparam int PIN_FSYNC = 12;
  localparam int PIN_CHAN = 13;
  localparam int PIN_BITCLK = 14;
  localparam int PIN_AUDIO = 15;
  localparam int PIN_OVF = 16;
  localparam int PIN_INTERP = 17;
  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_PORT_SEL = 8'h04;
  localparam logic [ADR_W-1:0] OFS_PORT_DATA = 8'h08;
  localparam logic [ADR_W-1:0] OFS_STEP = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_SHARED_DIR = 8'h10;
  localparam logic [ADR_W-1:0] OFS_PIN_STATE = 8'h14;
  localparam logic [ADR_W-1:0] OFS_SEG_BASE = 8'h20;
  localparam logic [ADR_W-1:0] OFS_SEG_LAST = 8'h2C;
  // control register fields
  localparam int CTRL_THIRD_BIAS = 0;
  localparam int CTRL_BATCH_CD = 1;
  localparam int CTRL_CHAN_INV = 2;
  localparam int CTRL_SUBCLK_DRIVE = 3;
  localparam int CTRL_W = 4;
  localparam int SEG_CD_SEL_LSB = 13;
  // reset values
  localparam logic [CTRL_W-1:0] RST_CTRL = 4'h0;
  localparam logic [NUM_PINS-1:0] RST_PORT_SEL = 18'h3_c000;
  localparam logic [NUM_PINS-1:0] RST_PORT_DATA = 18'h0_0001;
  localparam logic [NUM_SHARED-1:0] RST_SHARED_DIR = 4'h0;
  typedef enum logic [1:0] {
    LCDMX_BUS_IDLE = 2'b00,
    LCDMX_BUS_BUSY = 2'b01,
    LCDMX_BUS_ACK = 2'b10
  } lcdmx_bus_t;
endpackage

/* inc/lcdmx_seg_if.sv */
// Purpose: segment data memory port between control and storage
// Assumes: single clock, one write and one registered read port
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface lcdmx_seg_if;
  import lcdmx_pkg::*;
  logic we;
  logic [1:0] waddr;
  logic [NUM_PINS-1:0] wdata;
  logic [1:0] raddr;
  logic [NUM_PINS-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* hw/lcdmx_seg_mem.sv */
// Purpose: segment data store, one word of eighteen bits per common
// Assumes: read data are registered, one cycle after the address
// Notes: read of a word written in the same cycle returns the old word
`timescale 1ns/10ps
`default_nettype none
module lcdmx_seg_mem
  import lcdmx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // memory port
  lcdmx_seg_if.mem port
);
  typedef struct packed {
    logic [NUM_COMMONS-1:0][NUM_PINS-1:0] words;
    logic [NUM_PINS-1:0] rdata;
  } lcdmx_mem_state_t;

  lcdmx_mem_state_t state_reg;
  lcdmx_mem_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.rdata = state_reg.words[port.raddr];
    if (port.we)
    begin
      state_next.words[port.waddr] = port.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign port.rdata = state_reg.rdata;
endmodule
`default_nettype wire

/* verif/lcdmx_panel_model.sv */
// Purpose: far side of the pins: pull-ups and external subcode clock
// Assumes: shared pins pulled up off chip
// Notes: subcode clock stands low outside frames, 200 ns period
`timescale 1ns/10ps
`default_nettype none
module lcdmx_panel_model
  import lcdmx_pkg::*;
(
  // control
  input wire logic run,
  // pins
  input wire logic [NUM_PINS-1:0][1:0] pin_level,
  input wire logic [NUM_PINS-1:0] pin_oe,
  output logic subclk_pin,
  output logic [NUM_SHARED-1:0] shared_pin
);
  initial subclk_pin = 1'b0;
  always
  begin
    #100;
    subclk_pin = run ? ~subclk_pin : 1'b0;
  end
  // wire low only while driven to ground
  always_comb
  begin
    for (int i = 0; i < NUM_SHARED; i++)
    begin
      shared_pin[i] = !(pin_oe[14+i] && pin_level[14+i] == LVL_GND);
    end
  end
endmodule
`default_nettype wire

/* verif/test_lcd_segment_cd_signal_pin_mux.sv */
// Purpose: scenario bench for the segment pin multiplexer
// Assumes: registers reached over classic Wishbone
// Notes: one task per scenario
`timescale 1ns/10ps
`default_nettype none
module test_lcd_segment_cd_signal_pin_mux;
  import lcdmx_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'hf;
  logic [31:0] rd;
  logic [1:0] cidx = 2'h0;
  logic phase = 1'b0;
  logic run = 1'b0;
  logic sc_clk = 1'b0;
  logic sc_ld = 1'b0;
  logic [7:0] sc_byte = 8'h00;
  logic [6:0] cd = 7'h00;
  logic ext_clk;
  logic subclk_w;
  logic [NUM_SHARED-1:0] sh_in;
  logic [31:0] dat_o;
  logic ack;
  logic [NUM_PINS-1:0][1:0] lvl;
  logic [NUM_PINS-1:0] oe;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  assign subclk_w = oe[10] ? lvl[10][1] : ext_clk;
  lcdmx_top DUT (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .lcd_common_index(cidx), .lcd_frame_phase(phase),
    .cd_subcode_clk(sc_clk), .cd_subcode_load(sc_ld), .cd_subcode_byte(sc_byte),
    .cd_frame_sync(cd[0]), .cd_channel_clk(cd[1]), .cd_bit_clk(cd[2]),
    .cd_audio_data(cd[3]), .cd_overflow(cd[4]), .cd_interp(cd[5]), .cd_zero(cd[6]),
    .subclk_pin_in(subclk_w), .shared_port_bit_in(sh_in), .pin_level_o(lvl),
    .pin_oe_o(oe));
  lcdmx_panel_model PANEL (.run(run), .pin_level(lvl), .pin_oe(oe),
    .subclk_pin(ext_clk), .shared_pin(sh_in));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
    if (n >= 20) chk("wb_ack", 1, 0);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic pc(input int i, input logic [1:0] e);
    repeat (4) @(posedge clk_sys);
    chk($sformatf("level%0d", i), {30'h0, e}, {30'h0, lvl[i]});
  endtask
  task automatic t_reset;
    chk("oe", 32'h0000_3fff, {14'h0, oe});
    rdc("ctrl", OFS_CTRL, 32'h0000_0000);
    rdc("sel", OFS_PORT_SEL, 32'h0003_c000);
    rdc("data", OFS_PORT_DATA, 32'h0000_0001);
    rdc("dir", OFS_SHARED_DIR, 32'h0000_0000);
    sel <= 4'he;
    wb(1'b1, OFS_SHARED_DIR, 32'h0000_000f);
    sel <= 4'hf;
    rdc("dir_lane", OFS_SHARED_DIR, 32'h0000_0000);
    wb(1'b1, 8'h40, 32'h0000_00ff);
    rdc("unmapped", 8'h40, 32'h0000_0000);
    wb(1'b1, OFS_PIN_STATE, 32'h0000_0000);
    rdc("state", OFS_PIN_STATE, 32'h003c_3fff);
  endtask
  task automatic t_bias;
    wb(1'b1, OFS_SEG_BASE, 32'h0000_0001);
    for (int b = 0; b < 2; b++)
    begin
      wb(1'b1, OFS_CTRL, b);
      for (int p = 0; p < 2; p++)
      begin
        phase <= p[0];
        pc(0, p ? LVL_GND : LVL_VDD);
        pc(1, b ? (p ? LVL_TWO_THIRDS : LVL_THIRD) : (p ? LVL_VDD : LVL_GND));
      end
    end
    cidx <= 2'h1;
    pc(0, LVL_TWO_THIRDS);
    cidx <= 2'h0;
    phase <= 1'b0;
    wb(1'b1, OFS_CTRL, 32'h0000_0000);
  endtask
  task automatic t_port;
    wb(1'b1, OFS_PORT_SEL, 32'h0000_0003);
    pc(0, LVL_VDD);
    pc(1, LVL_GND);
    wb(1'b1, OFS_STEP, 32'h0000_0000);
    rdc("step", OFS_PORT_DATA, 32'h0000_0002);
    pc(1, LVL_VDD);
    wb(1'b1, OFS_PORT_DATA, 32'h0002_0000);
    wb(1'b1, OFS_STEP, 32'h0000_0000);
    rdc("wrap", OFS_STEP, 32'h0000_0001);
    wb(1'b1, OFS_PORT_SEL, 32'h0000_0000);
  endtask
  task automatic t_shared;
    wb(1'b1, OFS_PORT_SEL, 32'h0000_4000);
    wb(1'b1, OFS_PORT_DATA, 32'h0000_0000);
    rdc("in", OFS_PIN_STATE, 32'h0007_bfff);
    wb(1'b1, OFS_SHARED_DIR, 32'h0000_0001);
    pc(14, LVL_GND);
    chk("oe14", 1, oe[14]);
    rdc("pin", OFS_PIN_STATE, 32'h0003_ffff);
    wb(1'b1, OFS_PORT_DATA, 32'h0000_4000);
    repeat (4) @(posedge clk_sys);
    chk("oe14", 0, oe[14]);
    wb(1'b1, OFS_PORT_SEL, 32'h0000_0000);
    wb(1'b1, OFS_SHARED_DIR, 32'h0000_0000);
  endtask
  task automatic t_cd;
    wb(1'b1, OFS_SEG_BASE + 8'h04, 32'h0000_e000);
    wb(1'b1, OFS_SEG_BASE, 32'h0000_a000);
    wb(1'b1, OFS_PORT_SEL, 32'h0001_0000);
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, OFS_CTRL, k ? 32'h0000_0006 : 32'h0000_0002);
      for (int v = 0; v < 128; v += 37)
      begin
        cd <= v[6:0];
        pc(13, (v[1] ^ k[0]) ? LVL_VDD : LVL_GND);
        pc(14, v[2] ? LVL_VDD : LVL_GND);
        pc(15, v[3] ? LVL_VDD : LVL_GND);
        pc(9, v[6] ? LVL_VDD : LVL_GND);
        pc(12, v[0] ? LVL_VDD : LVL_GND);
        pc(16, v[4] ? LVL_VDD : LVL_GND);
        pc(17, v[5] ? LVL_VDD : LVL_GND);
      end
    end
    wb(1'b1, OFS_CTRL, 32'h0000_0000);
    wb(1'b1, OFS_PORT_SEL, 32'h0000_0000);
    wb(1'b1, OFS_SEG_BASE + 8'h04, 32'h0000_0000);
  endtask
  task automatic t_sub;
    wb(1'b1, OFS_SEG_BASE, 32'h0000_c000);
    sc_byte <= 8'ha5;
    sc_ld <= 1'b1;
    @(posedge clk_sys);
    sc_ld <= 1'b0;
    run <= 1'b1;
    chk("oe10", 0, oe[10]);
    for (int k = 0; k < 9; k++)
    begin
      @(posedge ext_clk);
      repeat (7) @(posedge clk_sys);
      chk("subdata", k < 8 ? 8'ha5 >> (7 - k) & 1 : 0, lvl[11][1]);
    end
    run <= 1'b0;
    wb(1'b1, OFS_CTRL, 32'h0000_0008);
    sc_clk <= 1'b1;
    pc(10, LVL_VDD);
    chk("oe10", 1, oe[10]);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_bias();
    t_port();
    t_shared();
    t_cd();
    t_sub();
    close_out();
  end
endmodule
`default_nettype wire
